// ===== design/nuws_pkg.sv
package nuws_pkg;
	// register byte offsets in the special function register space
	localparam logic [15:0] CTRL_OFS = 16'h0260;
	localparam logic [15:0] ADDR_LO_OFS = 16'h0762;
	localparam logic [15:0] ADDR_UP_OFS = 16'h0764;
	localparam logic [15:0] KEY_OFS = 16'h0766;

	// control register field positions
	localparam int GO_BIT = 15;
	localparam int PERMIT_BIT = 14;
	localparam int ABORT_BIT = 13;
	localparam int AUX_BIT = 8;
	localparam int OPSEL_W = 7;
	localparam int ADDR_UP_W = 8;
	localparam int KEY_W = 8;

	// operation_select decode
	localparam int OP_ERASE_BIT = 6;
	localparam int OP_EE_BIT = 2;
	localparam int OP_BLOCK_BIT = 0;

	// reset values
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [OPSEL_W-1:0] OPSEL_RST = 7'h00;

	// unlock key values
	localparam logic [KEY_W-1:0] KEY_FIRST = 8'h55;
	localparam logic [KEY_W-1:0] KEY_SECOND = 8'haa;

	// data memory window in program space
	localparam logic [23:0] EE_BASE = 24'h7ff000;
	localparam logic [23:0] EE_END = 24'h7ffffe;
	localparam int EE_WORDS = 4096;
	localparam int EE_AW = 12;
	localparam int BLOCK_WORDS = 16;
	localparam int BLOCK_AW = 4;
	localparam logic [15:0] ERASED_WORD = 16'hffff;

	// timing: nominal operation length
	localparam int CLK_MHZ = 125;
	localparam int OP_TIME_MS = 2;
	localparam int OP_CYCLES = OP_TIME_MS * 1000 * CLK_MHZ;

	typedef enum logic [1:0] {
		K_LOCKED = 2'b00,
		K_HALF = 2'b01,
		K_OPEN = 2'b11
	} nuws_key_type;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_RUN = 2'b01,
		S_COMMIT = 2'b11,
		S_FINISH = 2'b10
	} nuws_seq_type;
endpackage

// ===== design/nuws_mem_if.sv
`timescale 1ns/10ps
interface nuws_mem_if #(parameter int AW = 12);
	logic we;
	logic [AW-1:0] waddr;
	logic [15:0] wdata;
	logic [AW-1:0] raddr;
	logic [15:0] rdata;
	modport ctrl(output we, output waddr, output wdata, output raddr, input rdata);
	modport mem(input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ===== design/nuws_mem.sv
`timescale 1ns/10ps
module nuws_mem #(
	parameter int WORDS = 4096,
	parameter int AW = 12
) (
	input wire logic clk,
	nuws_mem_if.mem port
);
	logic [15:0] cell_q [WORDS];
	logic [15:0] rdata_q;

	generate
		if (WORDS < 1 || WORDS > (1 << AW)) begin : g_bad
			$error("nuws_mem: WORDS does not fit the address width");
		end
	endgenerate

	// contents survive every reset, as a nonvolatile array must
	always_ff @(posedge clk) begin
		if (port.we) begin
			cell_q[port.waddr] <= port.wdata;
		end
	end

	always_ff @(posedge clk) begin
		rdata_q <= cell_q[port.raddr];
	end

	assign port.rdata = rdata_q;
endmodule

// ===== design/nuws_sequencer.sv
`timescale 1ns/10ps
module nuws_sequencer #(
	parameter int OP_CYCLES = nuws_pkg::OP_CYCLES,
	parameter int EE_WORDS = nuws_pkg::EE_WORDS
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic por_reset,
	input wire logic ext_reset_cause,
	input wire logic wdt_reset_cause,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [15:0] sfr_addr,
	input wire logic [15:0] sfr_wdata,
	output logic [15:0] sfr_rdata_q,
	input wire logic tbl_rd,
	input wire logic tbl_wr,
	input wire logic [23:0] tbl_addr,
	input wire logic [15:0] tbl_wdata,
	output logic [15:0] tbl_rdata_q,
	output logic tbl_rvalid_q,
	input wire logic done_clear,
	output logic done_flag_q,
	output logic cpu_stall_q
);
	import nuws_pkg::*;

	generate
		if (OP_CYCLES < 2 || EE_WORDS < BLOCK_WORDS || EE_WORDS > (1 << EE_AW)) begin : g_bad
			$error("nuws_sequencer: unsupported OP_CYCLES or EE_WORDS");
		end
	endgenerate

	nuws_key_type key_st_q;
	nuws_seq_type state_q;
	logic go_q;
	logic permit_q;
	logic abort_q;
	logic aux_q;
	logic [OPSEL_W-1:0] opsel_q;
	logic [15:0] adr_lo_q;
	logic [ADDR_UP_W-1:0] adr_up_q;
	logic [31:0] cnt_q;
	logic [BLOCK_AW:0] word_q;
	logic [EE_AW-1:0] tgt_idx_q;
	logic tgt_ok_q;
	logic op_ee_q;
	logic op_erase_q;
	logic op_block_q;
	logic rd_p1_q;
	logic [15:0] latch_q [BLOCK_WORDS];

	logic ctrl_wr;
	logic key_wr;
	logic start;
	logic finish;
	logic busy;
	logic run_last;
	logic commit_last;
	logic [23:0] nv_addr;
	logic [EE_AW-1:0] wr_idx;

	nuws_mem_if #(.AW(EE_AW)) mem_bus();

	nuws_mem #(
		.WORDS(EE_WORDS),
		.AW(EE_AW)
	) u_mem (
		.clk(clk),
		.port(mem_bus.mem)
	);

	function automatic logic ee_hit(input logic [23:0] a);
		return (a >= EE_BASE) && (a <= EE_END);
	endfunction

	function automatic logic [EE_AW-1:0] ee_index(input logic [23:0] a);
		logic [23:0] off;
		off = a - EE_BASE;
		return off[EE_AW:1];
	endfunction

	assign ctrl_wr = sfr_wr && (sfr_addr == CTRL_OFS);
	assign key_wr = sfr_wr && (sfr_addr == KEY_OFS);
	assign nv_addr = {adr_up_q, adr_lo_q};
	assign busy = (state_q != S_IDLE);
	// permit_q is the value before this write, so go and permit in one write fail
	assign start = ctrl_wr && sfr_wdata[GO_BIT] && (key_st_q == K_OPEN)
		&& permit_q && !busy;
	assign finish = (state_q == S_FINISH);
	assign run_last = (state_q == S_RUN) && (cnt_q == 32'(OP_CYCLES - 1));
	assign commit_last = (state_q == S_COMMIT)
		&& (word_q == (op_block_q ? 5'(BLOCK_WORDS - 1) : 5'h00));

	// unlock key tracking: only the exact pair, then the go write, opens the gate
	always_ff @(posedge clk) begin
		if (rst) begin
			key_st_q <= K_LOCKED;
		end else if (sfr_wr) begin
			case (key_st_q)
				K_LOCKED: begin
					if (key_wr && sfr_wdata[KEY_W-1:0] == KEY_FIRST) begin
						key_st_q <= K_HALF;
					end
				end
				K_HALF: begin
					if (key_wr && sfr_wdata[KEY_W-1:0] == KEY_SECOND) begin
						key_st_q <= K_OPEN;
					end else if (key_wr && sfr_wdata[KEY_W-1:0] == KEY_FIRST) begin
						key_st_q <= K_HALF;
					end else begin
						key_st_q <= K_LOCKED;
					end
				end
				K_OPEN: begin
					// the go write consumes the unlock; any other register write breaks it
					key_st_q <= K_LOCKED;
				end
				default: begin
					key_st_q <= K_LOCKED;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			go_q <= CTRL_RST[GO_BIT];
		end else if (finish) begin
			go_q <= 1'b0;
		end else if (start) begin
			go_q <= 1'b1;
		end
	end

	// clearing permit mid-operation does not stop the running cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			permit_q <= CTRL_RST[PERMIT_BIT];
		end else if (ctrl_wr) begin
			permit_q <= sfr_wdata[PERMIT_BIT];
		end
	end

	// mode bits are frozen while an operation runs so the decode stays stable
	always_ff @(posedge clk) begin
		if (rst) begin
			aux_q <= CTRL_RST[AUX_BIT];
			opsel_q <= OPSEL_RST;
		end else if (ctrl_wr && !busy) begin
			aux_q <= sfr_wdata[AUX_BIT];
			opsel_q <= sfr_wdata[OPSEL_W-1:0];
		end
	end

	// the abort flag must outlive the reset that caused it; power-up or a control write with the abort bit clear clears it
	always_ff @(posedge clk) begin
		if (rst) begin
			if (por_reset) begin
				abort_q <= 1'b0;
			end else if ((ext_reset_cause || wdt_reset_cause) && busy) begin
				abort_q <= 1'b1;
			end
		end else if (ctrl_wr) begin
			abort_q <= sfr_wdata[ABORT_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			done_flag_q <= 1'b0;
		end else if (finish) begin
			done_flag_q <= 1'b1;
		end else if (done_clear) begin
			done_flag_q <= 1'b0;
		end
	end

	// address registers carry no reset so a retry after an abort hits the same word
	always_ff @(posedge clk) begin
		if (sfr_wr && sfr_addr == ADDR_LO_OFS) begin
			adr_lo_q <= sfr_wdata;
		end else if (tbl_wr || tbl_rd) begin
			adr_lo_q <= tbl_addr[15:0];
		end
	end

	always_ff @(posedge clk) begin
		if (sfr_wr && sfr_addr == ADDR_UP_OFS) begin
			adr_up_q <= sfr_wdata[ADDR_UP_W-1:0];
		end else if (tbl_wr || tbl_rd) begin
			adr_up_q <= tbl_addr[23:16];
		end
	end

	// table writes into the data window fill the block latches
	always_ff @(posedge clk) begin
		if (tbl_wr && ee_hit(tbl_addr)) begin
			latch_q[BLOCK_AW'(ee_index(tbl_addr))] <= tbl_wdata;
		end
	end

	// operation sequencer
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= S_IDLE;
		end else begin
			case (state_q)
				S_IDLE: begin
					if (start) begin
						state_q <= S_RUN;
					end
				end
				S_RUN: begin
					if (run_last) begin
						state_q <= (op_ee_q && tgt_ok_q) ? S_COMMIT : S_FINISH;
					end
				end
				S_COMMIT: begin
					if (commit_last) begin
						state_q <= S_FINISH;
					end
				end
				S_FINISH: begin
					state_q <= S_IDLE;
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	// completion timer models the nominal array cycle
	always_ff @(posedge clk) begin
		if (rst || state_q != S_RUN) begin
			cnt_q <= 32'h0000_0000;
		end else begin
			cnt_q <= cnt_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || state_q != S_COMMIT) begin
			word_q <= '0;
		end else begin
			word_q <= word_q + 5'h01;
		end
	end

	// target and kind are captured at start; later register writes do not move them
	// kind comes from the go write itself: opsel_q only takes that write one edge later
	always_ff @(posedge clk) begin
		if (rst) begin
			tgt_idx_q <= '0;
			tgt_ok_q <= 1'b0;
			op_ee_q <= 1'b0;
			op_erase_q <= 1'b0;
			op_block_q <= 1'b0;
		end else if (start) begin
			tgt_idx_q <= ee_index(nv_addr);
			tgt_ok_q <= ee_hit(nv_addr);
			op_ee_q <= sfr_wdata[OP_EE_BIT];
			op_erase_q <= sfr_wdata[OP_ERASE_BIT];
			op_block_q <= sfr_wdata[OP_BLOCK_BIT];
		end
	end

	// only program flash work holds the core; data memory work runs alongside
	always_ff @(posedge clk) begin
		if (rst) begin
			cpu_stall_q <= 1'b0;
		end else if (start && !sfr_wdata[OP_EE_BIT]) begin
			cpu_stall_q <= 1'b1;
		end else if (finish) begin
			cpu_stall_q <= 1'b0;
		end
	end

	// block operations align to a 16-word boundary and write one word per cycle
	assign wr_idx = op_block_q
		? ((tgt_idx_q & ~EE_AW'(BLOCK_WORDS - 1)) | EE_AW'(word_q[BLOCK_AW-1:0]))
		: tgt_idx_q;
	assign mem_bus.we = (state_q == S_COMMIT);
	assign mem_bus.waddr = wr_idx;
	assign mem_bus.wdata = op_erase_q ? ERASED_WORD
		: latch_q[BLOCK_AW'(wr_idx)];
	// reads are not held off while a commit runs; the data may be stale then
	assign mem_bus.raddr = ee_index(tbl_addr);

	always_ff @(posedge clk) begin
		if (rst) begin
			rd_p1_q <= 1'b0;
			tbl_rvalid_q <= 1'b0;
			tbl_rdata_q <= 16'h0000;
		end else begin
			rd_p1_q <= tbl_rd && ee_hit(tbl_addr);
			tbl_rvalid_q <= rd_p1_q;
			if (rd_p1_q) begin
				tbl_rdata_q <= mem_bus.rdata;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sfr_rdata_q <= 16'h0000;
		end else if (sfr_rd) begin
			case (sfr_addr)
				CTRL_OFS: sfr_rdata_q <= {go_q, permit_q, abort_q, 4'h0, aux_q, 1'b0, opsel_q};
				ADDR_LO_OFS: sfr_rdata_q <= adr_lo_q;
				ADDR_UP_OFS: sfr_rdata_q <= {8'h00, adr_up_q};
				KEY_OFS: sfr_rdata_q <= 16'h0000;
				default: sfr_rdata_q <= 16'h0000;
			endcase
		end
	end

	a_start_needs_key: assert property (@(posedge clk) disable iff (rst)
		$rose(state_q == S_RUN) |-> $past(key_st_q) == K_OPEN)
		else $error("operation started without unlock");

	a_start_needs_permit: assert property (@(posedge clk) disable iff (rst)
		(ctrl_wr && sfr_wdata[GO_BIT] && !permit_q) |=> !$rose(go_q))
		else $error("go accepted without earlier permit");

	a_zero_keeps_go: assert property (@(posedge clk) disable iff (rst)
		(go_q && ctrl_wr && !sfr_wdata[GO_BIT] && !finish) |=> go_q)
		else $error("software write cleared go");

	a_go_clear_end: assert property (@(posedge clk) disable iff (rst)
		finish |=> !go_q && state_q == S_IDLE)
		else $error("go not cleared at finish");

	a_done_on_finish: assert property (@(posedge clk) disable iff (rst)
		finish |=> done_flag_q)
		else $error("done flag not set at finish");

	a_ee_no_stall: assert property (@(posedge clk) disable iff (rst)
		(busy && op_ee_q) |-> !cpu_stall_q)
		else $error("data memory operation stalled core");

	a_flash_stalls: assert property (@(posedge clk) disable iff (rst)
		(state_q == S_RUN && !op_ee_q) |-> cpu_stall_q)
		else $error("flash operation did not stall core");

	a_permit_held: assert property (@(posedge clk) disable iff (rst)
		(permit_q && !ctrl_wr) |=> permit_q)
		else $error("permit cleared without software");

	a_key_reads_zero: assert property (@(posedge clk) disable iff (rst)
		(sfr_rd && (sfr_addr == KEY_OFS || sfr_addr == ADDR_UP_OFS))
		|=> sfr_rdata_q[15:8] == 8'h00)
		else $error("unimplemented bits read nonzero");

	a_abort_on_reset: assert property (@(posedge clk) disable iff (por_reset)
		(rst && busy && (ext_reset_cause || wdt_reset_cause)) |=> abort_q)
		else $error("abort flag not set by reset");

	a_table_read: assert property (@(posedge clk) disable iff (rst)
		(tbl_rd && ee_hit(tbl_addr)) |-> ##2 tbl_rvalid_q)
		else $error("table read not answered in two cycles");

	a_block_length: assert property (@(posedge clk) disable iff (rst)
		($rose(state_q == S_COMMIT) && op_block_q)
		|-> ##15 (state_q == S_COMMIT && word_q == 5'(BLOCK_WORDS - 1)) ##1 finish)
		else $error("block commit not sixteen words");
endmodule

// ===== tb/nuws_core_model.sv
`timescale 1ns/10ps
module nuws_core_model (
	input wire logic clk,
	output logic sfr_wr,
	output logic sfr_rd,
	output logic [15:0] sfr_addr,
	output logic [15:0] sfr_wdata,
	input wire logic [15:0] sfr_rdata_q,
	output logic tbl_rd,
	output logic tbl_wr,
	output logic [23:0] tbl_addr,
	output logic [15:0] tbl_wdata,
	input wire logic [15:0] tbl_rdata_q,
	input wire logic tbl_rvalid_q,
	output logic done_clear
);
	import nuws_pkg::*;
	initial begin
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		tbl_rd = 1'b0;
		tbl_wr = 1'b0;
		done_clear = 1'b0;
		sfr_addr = 16'h0000;
		sfr_wdata = 16'h0000;
		tbl_wdata = 16'h0000;
		tbl_addr = 24'h000000;
	end
	// released buses show the inverse so a stale value never looks valid
	task automatic sfr_write(input logic [15:0] a, input logic [15:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_addr = ~a;
		sfr_wdata = ~d;
		sfr_wr = 1'b0;
	endtask
	task automatic sfr_read(input logic [15:0] a, output logic [15:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge clk);
		sfr_addr = ~a;
		sfr_rd = 1'b0;
		d = sfr_rdata_q;
	endtask
	task automatic tbl_write(input logic [23:0] a, input logic [15:0] d);
		@(negedge clk);
		tbl_addr = a;
		tbl_wdata = d;
		tbl_wr = 1'b1;
		@(negedge clk);
		tbl_addr = ~a;
		tbl_wdata = ~d;
		tbl_wr = 1'b0;
	endtask
	task automatic tbl_read(input logic [23:0] a, output logic [15:0] d, output logic ok);
		ok = 1'b0;
		d = 16'h0;
		@(negedge clk);
		tbl_addr = a;
		tbl_rd = 1'b1;
		@(negedge clk);
		tbl_addr = ~a;
		tbl_rd = 1'b0;
		for (int i = 0; i < 4; i++) begin
			@(negedge clk);
			if (!ok && tbl_rvalid_q === 1'b1) begin
				ok = 1'b1;
				d = tbl_rdata_q;
			end
		end
	endtask
	// nothing else is issued between key and go, as an interrupt hold would ensure
	task automatic unlock_and_go(input logic [15:0] ctrl);
		sfr_write(KEY_OFS, {8'h00, KEY_FIRST});
		sfr_write(KEY_OFS, {8'h00, KEY_SECOND});
		sfr_write(CTRL_OFS, ctrl | 16'h8000);
		repeat (2) @(negedge clk); // two idle slots after go
	endtask
	task automatic clear_done();
		@(negedge clk);
		done_clear = 1'b1;
		@(negedge clk);
		done_clear = 1'b0;
	endtask
endmodule

// ===== tb/nvm_unlock_write_sequencer_tb_top.sv
`timescale 1ns/10ps
module nvm_unlock_write_sequencer_tb_top;
	import nuws_pkg::*;
	logic clk = 1'b0, rst = 1'b1, por_reset = 1'b1, ext_c = 1'b0, wdt_c = 1'b0;
	logic sfr_wr, sfr_rd, tbl_rd, tbl_wr, done_clear, tbl_rvalid_q, done_flag_q, cpu_stall_q;
	logic [15:0] sfr_addr, sfr_wdata, sfr_rdata_q, tbl_wdata, tbl_rdata_q, v;
	logic [23:0] tbl_addr;
	logic ok;
	int mismatches = 0, checks_done = 0;
	initial forever #4 clk = ~clk;
	nuws_sequencer #(.OP_CYCLES(20)) u_nuws_sequencer (.clk(clk), .rst(rst),
		.por_reset(por_reset), .ext_reset_cause(ext_c), .wdt_reset_cause(wdt_c),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
		.sfr_rdata_q(sfr_rdata_q), .tbl_rd(tbl_rd), .tbl_wr(tbl_wr), .tbl_addr(tbl_addr),
		.tbl_wdata(tbl_wdata), .tbl_rdata_q(tbl_rdata_q), .tbl_rvalid_q(tbl_rvalid_q),
		.done_clear(done_clear), .done_flag_q(done_flag_q), .cpu_stall_q(cpu_stall_q));
	nuws_core_model u_nuws_core_model (.clk(clk), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q),
		.tbl_rd(tbl_rd), .tbl_wr(tbl_wr), .tbl_addr(tbl_addr), .tbl_wdata(tbl_wdata),
		.tbl_rdata_q(tbl_rdata_q), .tbl_rvalid_q(tbl_rvalid_q), .done_clear(done_clear));
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check_word(input string n, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic check_flag(input string n, input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] e, input string n);
		u_nuws_core_model.sfr_read(a, v);
		check_word(n, e, v);
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		u_nuws_core_model.sfr_write(a, d);
	endtask
	task automatic do_reset(input logic p, input logic e, input logic w);
		@(negedge clk);
		rst = 1'b1;
		por_reset = p;
		ext_c = e;
		wdt_c = w;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		por_reset = 1'b0;
		ext_c = 1'b0;
		wdt_c = 1'b0;
	endtask
	// software may not treat the operation as over before the flag says so
	task automatic wait_done();
		for (int i = 0; i < 200 && done_flag_q !== 1'b1; i++)
			@(negedge clk);
		check_flag("done_flag", 1'b1, done_flag_q);
		if (done_flag_q !== 1'b1)
			report_and_stop();
		u_nuws_core_model.clear_done();
		check_flag("done_cleared", 1'b0, done_flag_q);
	endtask
	task automatic tread(input logic [23:0] a, input logic [15:0] e);
		u_nuws_core_model.tbl_read(a, v, ok);
		check_flag("tbl_valid", 1'b1, ok);
		check_word("tbl_data", e, v);
	endtask
	initial begin
		do_reset(1'b1, 1'b0, 1'b0);
		rd(CTRL_OFS, 16'h0000, "ctrl_reset");
		wr(KEY_OFS, 16'hff55);
		rd(KEY_OFS, 16'h0000, "key_read");
		rd(16'h0400, 16'h0000, "unmapped");
		wr(ADDR_UP_OFS, 16'hffff);
		rd(ADDR_UP_OFS, 16'h00ff, "addr_up");
		wr(CTRL_OFS, 16'h1f7f);
		rd(CTRL_OFS, 16'h017f, "ctrl_fields");
		wr(ADDR_UP_OFS, 16'h007f);
		wr(ADDR_LO_OFS, 16'hf020);
		rd(ADDR_LO_OFS, 16'hf020, "addr_lo");
		$display("test registers done");
		wr(CTRL_OFS, 16'h0004);
		u_nuws_core_model.unlock_and_go(16'h4004);
		rd(CTRL_OFS, 16'h4004, "go_with_permit");
		wr(CTRL_OFS, 16'hc004);
		rd(CTRL_OFS, 16'h4004, "go_no_key");
		wr(KEY_OFS, 16'h00aa);
		wr(KEY_OFS, 16'h0055);
		wr(CTRL_OFS, 16'hc004);
		rd(CTRL_OFS, 16'h4004, "go_bad_order");
		wr(KEY_OFS, 16'h0055);
		wr(KEY_OFS, 16'h00aa);
		wr(ADDR_LO_OFS, 16'hf020);
		wr(CTRL_OFS, 16'hc004);
		rd(CTRL_OFS, 16'h4004, "go_key_broken");
		check_flag("no_done", 1'b0, done_flag_q);
		$display("test refusals done");
		u_nuws_core_model.unlock_and_go(16'h4045);
		check_flag("ee_no_stall", 1'b0, cpu_stall_q);
		wr(CTRL_OFS, 16'h4045);
		rd(CTRL_OFS, 16'hc045, "go_sticky");
		wait_done();
		rd(CTRL_OFS, 16'h4045, "go_cleared");
		u_nuws_core_model.tbl_write(EE_BASE + 24'h24, 16'h1234);
		u_nuws_core_model.unlock_and_go(16'h4004);
		wait_done();
		tread(EE_BASE + 24'h24, 16'h1234);
		tread(EE_BASE + 24'h22, ERASED_WORD);
		for (int i = 0; i < 16; i++)
			u_nuws_core_model.tbl_write(EE_BASE + 24'h40 + 24'(2 * i), 16'ha500 + 16'(i));
		u_nuws_core_model.unlock_and_go(16'h4005);
		wait_done();
		for (int i = 0; i < 16; i++)
			tread(EE_BASE + 24'h40 + 24'(2 * i), 16'ha500 + 16'(i));
		u_nuws_core_model.tbl_read(EE_BASE - 24'h2, v, ok);
		check_flag("outside_window", 1'b0, ok);
		$display("test data memory done");
		u_nuws_core_model.unlock_and_go(16'h4041);
		check_flag("flash_stall", 1'b1, cpu_stall_q);
		wait_done();
		check_flag("flash_stall_end", 1'b0, cpu_stall_q);
		$display("test flash done");
		for (int j = 0; j < 2; j++) begin
			u_nuws_core_model.tbl_write(EE_BASE + 24'h30, 16'h5a5a);
			wr(CTRL_OFS, 16'h4004);
			u_nuws_core_model.unlock_and_go(16'h4004);
			repeat (3) @(negedge clk);
			do_reset(1'b0, j == 0, j == 1);
			rd(CTRL_OFS, 16'h2000, "abort_flag");
			rd(ADDR_LO_OFS, 16'hf030, "addr_kept");
		end
		do_reset(1'b1, 1'b0, 1'b0);
		rd(CTRL_OFS, 16'h0000, "power_up");
		$display("test abort done");
		report_and_stop();
	end
endmodule
